// [shared/homseq_map.svh]
// register offsets, reset values and timing counts of the homing sequencer
`ifndef HOMSEQ_MAP_SVH
`define HOMSEQ_MAP_SVH
`define HS_ADDR_CTRL 8'h00
`define HS_ADDR_FAST 8'h04
`define HS_ADDR_SLOW 8'h08
`define HS_ADDR_COARSE 8'h0C
`define HS_ADDR_FINE 8'h10
`define HS_ADDR_METHOD 8'h14
`define HS_ADDR_ACCEL 8'h18
`define HS_ADDR_STATUS 8'h1C
`define HS_ADDR_POS 8'h20
`define HS_CTRL_ENABLE 0
`define HS_CTRL_PULSE_TRAIN 1
`define HS_CTRL_CFS_LSB 4
`define HS_STAT_DONE 0
`define HS_STAT_BUSY 1
`define HS_STAT_FAULT 2
`define HS_STAT_STATE_LSB 4
`define HS_FAST_RST 12'h5DC
`define HS_FAST_MAX 12'hBB8
`define HS_SLOW_RST 8'h1E
`define HS_SLOW_MAX 8'hC8
`define HS_OFS_MAX 16'h270F
`define HS_ACCEL_RST 16'h0064
`define HS_COARSE_UNIT 32'h0000_2710
`define HS_RAMP_RPM 32'h0000_03E8
`define HS_CLK_PERIOD_NS 50
`define HS_MS_NS 1000000
`define HS_CYC_PER_MS (`HS_MS_NS / `HS_CLK_PERIOD_NS)
`define HS_METHOD_AUTO 4'hB
`define HS_CFS_AUTO 4'h1
`endif

// [shared/homseq_pkg.sv]
// types of the homing sequencer
package homseq_pkg;
    typedef enum logic [2:0] {
        HS_IDLE, HS_SEARCH, HS_LEAVE, HS_OFFSET, HS_DONE
    } homseq_state_t;

    // pin inputs, carried together through the synchroniser
    typedef struct packed {
        logic originSwitch;
        logic encIndex;
        logic encStep;
        logic encDir;
        logic fwdOvertravel;
        logic revOvertravel;
        logic homeStart;
        logic posCompleted;
    } homseq_pins_t;

    typedef struct packed {
        homseq_state_t state;
        logic enable;
        logic pulseTrain;
        logic [3:0] ctrlFuncSel;
        logic [11:0] fastSpeed;
        logic [7:0] slowSpeed;
        logic [15:0] coarseOffset;
        logic [15:0] fineOffset;
        logic [3:0] methodPend;
        logic [3:0] methodAct;
        logic [15:0] accelTime;
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] rdata;
        homseq_pins_t prev;
        logic [31:0] position;
        logic [31:0] remain;
        logic done;
        logic fault;
        logic autoPend;
        logic reverse;
        logic [11:0] target;
    } homseq_regs_t;

    typedef struct packed {
        logic [11:0] speed;
        logic [31:0] acc;
    } homseq_ramp_t;
endpackage : homseq_pkg

// [verilog/homseq_sync.sv]
// two-stage synchroniser for the pin inputs
module homseq_sync #(
    parameter int W = 8
) (
    input wire logic mclk, // control clock
    input wire logic rst, // async reset, high
    input wire logic [W-1:0] d, // asynchronous pins
    output logic [W-1:0] q // synchronised pins
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : homseq_sync

// [verilog/homseq_ramp.sv]
// speed ramp: 1000 rpm per accelTime ms, 1 rpm steps
`include "homseq_map.svh"
module homseq_ramp (
    input wire logic mclk, // control clock
    input wire logic rst, // async reset, high
    input wire logic [11:0] target, // wanted speed, rpm
    input wire logic [15:0] accelTime, // ms to reach 1000 rpm
    output logic [11:0] speed // ramped speed, rpm
);
    homseq_pkg::homseq_ramp_t q;
    homseq_pkg::homseq_ramp_t s;
    logic [31:0] thr;

    // accumulate 1000 per cycle against accelTime*cycles-per-ms per step
    always_comb begin
        s = q;
        thr = 32'(accelTime) * 32'(`HS_CYC_PER_MS);
        if (q.speed == target || accelTime == 16'h0000) begin
            s.speed = target; // zero time means a step change
            s.acc = 32'h0000_0000;
        end else if (q.acc + `HS_RAMP_RPM >= thr) begin
            s.acc = q.acc + `HS_RAMP_RPM - thr;
            s.speed = (q.speed < target) ? q.speed + 12'h001 : q.speed - 12'h001;
        end else begin
            s.acc = q.acc + `HS_RAMP_RPM;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= s;
        end
    end

    assign speed = q.speed;
endmodule : homseq_ramp

// [verilog/homing_sequencer.sv]
// homing sequencer: method selection, search, origin pick-up and offset
//
// Implementation choices: the AHB-Lite register port and the address map.
`include "homseq_map.svh"

// Behaviour
// RULE1 - search at fast speed, 0..3000, default 1500
// RULE2 - leave switch at slow speed, 0..200, default 30
// RULE3 - offset is coarse*10000 plus fine, signed
// RULE4 - methods 7, 9 drop positive offset
// RULE5 - methods 8, 10 drop negative offset
// RULE6 - accel time ms to 1000 rpm
// RULE7 - method change applies after power-up only
// RULE8 - method 0 takes present position as origin
// RULE9 - methods 1/2: origin switch decel and origin
// RULE10 - methods 3/4: switch decel, index origin
// RULE11 - methods 5/6: index decel and origin
// RULE12 - methods 7/8: overtravel decel and origin
// RULE13 - methods 9/10: overtravel decel, index origin
// RULE14 - method 11 auto-homes, pulse train, select 1
// RULE15 - controller starts homing with rising start edge
// RULE16 - origin switch high means valid
// RULE17 - start only while positioning completed
// RULE18 - no start while either overtravel active
// RULE19 - at end stop, zero position, flag done
// RULE20 - method above 11 starts nothing
module homing_sequencer (
    input wire logic mclk, // 20 MHz control clock
    input wire logic rst, // async reset, high
    input wire logic hsel, // ahb slave select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, word only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response
    output logic [31:0] hrdata, // ahb read data
    input wire homseq_pkg::homseq_pins_t pins, // external pins, async
    input wire logic servoOn, // servo on, drive logic
    input wire logic powerUpLoad, // power-up pulse, drive logic
    output logic [11:0] speedCmd, // speed command, rpm
    output logic dirReverse, // direction of motion
    output logic motorRun, // motion under homing control
    output logic homeDone, // homing completed
    output logic homingBusy // homing run in progress
);
    homseq_pkg::homseq_regs_t q;
    homseq_pkg::homseq_regs_t s;
    homseq_pkg::homseq_pins_t p;
    logic [11:0] rampSpeed;
    logic startRise;
    logic orgRise;
    logic orgFall;
    logic idxRise;
    logic encRise;
    logic fwdRise;
    logic fwdFall;
    logic revRise;
    logic revFall;
    logic decelHit;
    logic originHit;
    logic limitHit;
    logic noOt;
    logic methodOk;
    logic startReq;
    logic [31:0] offset;
    logic [31:0] effOffset;

    // every pin is asynchronous; two flops stand before any use
    homseq_sync #(.W(8)) uSync (
        .mclk(mclk),
        .rst(rst),
        .d(pins),
        .q(p)
    );

    // speed command follows the target through the ramp
    homseq_ramp uRamp (
        .mclk(mclk),
        .rst(rst),
        .target(q.target),
        .accelTime(q.accelTime), // RULE6
        .speed(rampSpeed)
    );

    // limit a written value to the documented span
    function automatic logic [15:0] clampSigned(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        if (!v[15] && v > `HS_OFS_MAX) begin
            r = `HS_OFS_MAX;
        end else if (v[15] && (~v + 16'h0001) > `HS_OFS_MAX) begin
            r = ~`HS_OFS_MAX + 16'h0001;
        end
        return r;
    endfunction : clampSigned

    // register read view, taken from the updated state
    function automatic logic [31:0] readMux(input homseq_pkg::homseq_regs_t r,
                                            input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `HS_ADDR_CTRL: begin
                d[`HS_CTRL_ENABLE] = r.enable;
                d[`HS_CTRL_PULSE_TRAIN] = r.pulseTrain;
                d[`HS_CTRL_CFS_LSB +: 4] = r.ctrlFuncSel;
            end
            `HS_ADDR_FAST: d[11:0] = r.fastSpeed;
            `HS_ADDR_SLOW: d[7:0] = r.slowSpeed;
            `HS_ADDR_COARSE: d = {{16{r.coarseOffset[15]}}, r.coarseOffset};
            `HS_ADDR_FINE: d = {{16{r.fineOffset[15]}}, r.fineOffset};
            `HS_ADDR_METHOD: d[7:0] = {r.methodAct, r.methodPend};
            `HS_ADDR_ACCEL: d[15:0] = r.accelTime;
            `HS_ADDR_STATUS: begin
                d[`HS_STAT_DONE] = r.done;
                d[`HS_STAT_BUSY] = (r.state != homseq_pkg::HS_IDLE)
                                   && (r.state != homseq_pkg::HS_DONE);
                d[`HS_STAT_FAULT] = r.fault;
                d[`HS_STAT_STATE_LSB +: 3] = r.state;
            end
            `HS_ADDR_POS: d = r.position;
            default: d = 32'h0000_0000; // unmapped reads as zero
        endcase
        return d;
    endfunction : readMux

    // edges of the synchronised pins
    always_comb begin
        startRise = p.homeStart && !q.prev.homeStart; // RULE15
        orgRise = p.originSwitch && !q.prev.originSwitch; // RULE16
        orgFall = !p.originSwitch && q.prev.originSwitch;
        idxRise = p.encIndex && !q.prev.encIndex;
        encRise = p.encStep && !q.prev.encStep;
        fwdRise = p.fwdOvertravel && !q.prev.fwdOvertravel;
        fwdFall = !p.fwdOvertravel && q.prev.fwdOvertravel;
        revRise = p.revOvertravel && !q.prev.revOvertravel;
        revFall = !p.revOvertravel && q.prev.revOvertravel;
    end

    // deceleration and origin sources per method
    always_comb begin
        decelHit = 1'b0;
        originHit = 1'b0;
        case (q.methodAct)
            4'h1, 4'h2, 4'hB: begin
                decelHit = orgRise; // RULE9
                originHit = orgFall; // RULE9
            end

            4'h3, 4'h4: begin
                decelHit = orgRise; // RULE10
                originHit = idxRise; // RULE10
            end

            4'h5, 4'h6: begin
                decelHit = idxRise; // RULE11
                originHit = idxRise; // RULE11
            end

            4'h7: begin
                decelHit = fwdRise; // RULE12
                originHit = fwdFall; // RULE12
            end

            4'h8: begin
                decelHit = revRise; // RULE12
                originHit = revFall; // RULE12
            end

            4'h9: begin
                decelHit = fwdRise; // RULE13
                originHit = idxRise; // RULE13
            end

            4'hA: begin
                decelHit = revRise; // RULE13
                originHit = idxRise; // RULE13
            end

            default: begin
                decelHit = 1'b0;
                originHit = 1'b0;
            end
        endcase
    end

    // offset forming and suppression on the limit methods
    always_comb begin
        offset = 32'($signed(q.coarseOffset)) * `HS_COARSE_UNIT
                 + 32'($signed(q.fineOffset)); // RULE3
        effOffset = offset;
        if ((q.methodAct == 4'h7 || q.methodAct == 4'h9) && !offset[31]
            && offset != 32'h0000_0000) begin
            effOffset = 32'h0000_0000; // RULE4
        end
        if ((q.methodAct == 4'h8 || q.methodAct == 4'hA) && offset[31]) begin
            effOffset = 32'h0000_0000; // RULE5
        end
    end

    // start qualification
    always_comb begin
        noOt = !(servoOn && (p.fwdOvertravel || p.revOvertravel)); // RULE18
        methodOk = q.methodAct <= `HS_METHOD_AUTO; // RULE20
        if (q.methodAct == `HS_METHOD_AUTO) begin
            // auto method only in pulse-train position control
            methodOk = q.pulseTrain && q.ctrlFuncSel == `HS_CFS_AUTO; // RULE14
        end
        startReq = (startRise || (q.autoPend && servoOn)) && q.enable && servoOn
                   && p.posCompleted && noOt && methodOk; // RULE17
        // a limit in the running direction that is not the target ends the search with a fault
        limitHit = q.reverse ? (p.revOvertravel && q.methodAct != 4'h8
                                && q.methodAct != 4'hA)
                             : (p.fwdOvertravel && q.methodAct != 4'h7
                                && q.methodAct != 4'h9);
    end

    // next state: bus, configuration and sequencer in one copy
    always_comb begin
        s = q;
        // previous pin levels for the edge detectors
        s.prev = p;
        // encoder position, counted in every state
        if (encRise) begin
            s.position = p.encDir ? q.position - 32'h0000_0001
                                  : q.position + 32'h0000_0001;
        end
        // data phase of a write; settings act at once except the method
        if (q.wrPend) begin
            s.wrPend = 1'b0;
            case (q.wrAddr)
                `HS_ADDR_CTRL: begin
                    s.enable = hwdata[`HS_CTRL_ENABLE];
                    s.pulseTrain = hwdata[`HS_CTRL_PULSE_TRAIN];
                    s.ctrlFuncSel = hwdata[`HS_CTRL_CFS_LSB +: 4];
                end
                `HS_ADDR_FAST: s.fastSpeed = (hwdata[31:12] != 20'h00000
                    || hwdata[11:0] > `HS_FAST_MAX) ? `HS_FAST_MAX : hwdata[11:0];
                `HS_ADDR_SLOW: s.slowSpeed = (hwdata[31:8] != 24'h000000
                    || hwdata[7:0] > `HS_SLOW_MAX) ? `HS_SLOW_MAX : hwdata[7:0];
                `HS_ADDR_COARSE: s.coarseOffset = clampSigned(hwdata[15:0]);
                `HS_ADDR_FINE: s.fineOffset = clampSigned(hwdata[15:0]);
                `HS_ADDR_METHOD: s.methodPend = hwdata[3:0]; // RULE7
                `HS_ADDR_ACCEL: s.accelTime = hwdata[15:0];
                default: s.wrPend = 1'b0; // read-only and unmapped: ignored
            endcase
        end
        // the method in use is only taken over at power-up
        if (powerUpLoad) begin
            s.methodAct = s.methodPend; // RULE7
            s.autoPend = s.methodPend == `HS_METHOD_AUTO; // RULE14
        end
        case (q.state)
            homseq_pkg::HS_IDLE, homseq_pkg::HS_DONE: begin
                s.target = 12'h000;
                if (startReq) begin
                    s.autoPend = 1'b0;
                    s.done = 1'b0;
                    s.fault = 1'b0;
                    if (q.methodAct == 4'h0) begin
                        s.position = 32'h0000_0000; // RULE8
                        s.done = 1'b1; // RULE8
                        s.state = homseq_pkg::HS_DONE;
                    end else begin
                        s.reverse = !q.methodAct[0]; // even methods search reverse
                        s.target = q.fastSpeed; // RULE1
                        s.state = homseq_pkg::HS_SEARCH;
                    end
                end
            end

            homseq_pkg::HS_SEARCH: begin
                s.target = q.fastSpeed; // RULE1
                if (decelHit) begin
                    // back off the trigger slowly to pick up the origin
                    s.reverse = !q.reverse;
                    s.target = {4'h0, q.slowSpeed}; // RULE2
                    s.state = homseq_pkg::HS_LEAVE;
                end else if (limitHit) begin
                    s.fault = 1'b1;
                    s.state = homseq_pkg::HS_IDLE;
                end
            end

            homseq_pkg::HS_LEAVE: begin
                s.target = {4'h0, q.slowSpeed}; // RULE2
                if (originHit) begin
                    s.reverse = effOffset[31];
                    s.remain = effOffset[31] ? ~effOffset + 32'h0000_0001 : effOffset;
                    s.state = homseq_pkg::HS_OFFSET;
                end
            end

            homseq_pkg::HS_OFFSET: begin
                s.target = {4'h0, q.slowSpeed};
                // count the offset down, one encoder step at a time
                if (encRise && q.remain != 32'h0000_0000) begin
                    s.remain = q.remain - 32'h0000_0001;
                end
                if (q.remain == 32'h0000_0000) begin
                    s.target = 12'h000; // RULE19
                    s.position = 32'h0000_0000; // RULE19
                    s.done = 1'b1; // RULE19
                    s.state = homseq_pkg::HS_DONE;
                end
            end

            default: s.state = homseq_pkg::HS_IDLE;
        endcase
        // address phase; read sees this cycle's write already applied
        if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
                s.wrPend = 1'b1;
                s.wrAddr = haddr[7:0];
            end else begin
                s.rdata = readMux(s, haddr[7:0]);
            end
        end
    end

    // the one state register; reset loads the default settings
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.state <= homseq_pkg::HS_IDLE;
            q.fastSpeed <= `HS_FAST_RST;
            q.slowSpeed <= `HS_SLOW_RST;
            q.accelTime <= `HS_ACCEL_RST;
        end else begin
            q <= s;
        end
    end

    // zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    // ramp works on magnitude only; a direction flip is not slowed to zero first
    assign speedCmd = rampSpeed;
    assign dirReverse = q.reverse;
    assign motorRun = (q.state != homseq_pkg::HS_IDLE) && (q.state != homseq_pkg::HS_DONE);
    assign homingBusy = motorRun;
    assign homeDone = q.done;
endmodule : homing_sequencer

// [sim/homseq_checker.sv]
// assertion checker on the homing sequencer ports
module homseq_checker (
    input wire logic mclk, // control clock
    input wire logic rst, // async reset, high
    input wire logic hsel, // ahb select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // slave response
    input wire logic [31:0] hrdata, // read data
    input wire homseq_pkg::homseq_pins_t pins, // external pins
    input wire logic servoOn, // servo on
    input wire logic powerUpLoad, // power-up pulse
    input wire logic [11:0] speedCmd, // speed command
    input wire logic dirReverse, // direction
    input wire logic motorRun, // motion active
    input wire logic homeDone, // homing done
    input wire logic homingBusy // run in progress
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // pins pass two flops, so a gate held three cycles blocks a start; the sequences ask four
    sequence posLow;
        !pins.posCompleted [*4];
    endsequence
    sequence otHeld;
        (servoOn && (pins.fwdOvertravel || pins.revOvertravel)) [*4];
    endsequence

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    busy_run_a: assert property (homingBusy == motorRun)
        else $error("busy differs from motion");
    posc_gate_a: assert property (posLow |=> !$rose(motorRun))
        else $error("start without positioning completed");
    posc_past_a: assert property ($rose(homingBusy) |-> $past(pins.posCompleted, 3))
        else $error("run began without positioning completed");
    ot_gate_a: assert property (otHeld |=> !$rose(motorRun))
        else $error("start during overtravel");
    done_still_a: assert property (homeDone |-> !motorRun)
        else $error("done while moving");
    done_hold_a: assert property ($fell(homeDone) |-> $rose(motorRun))
        else $error("done dropped without a new start");
    fast_cap_a: assert property (speedCmd <= 12'hBB8)
        else $error("speed above the top of the range");
    rdata_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite)
        |=> $stable(hrdata))
        else $error("read data moved without a read");
endmodule : homseq_checker

bind homing_sequencer homseq_checker u_homseq_checker (
    .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .pins, .servoOn, .powerUpLoad, .speedCmd,
    .dirReverse, .motorRun, .homeDone, .homingBusy
);

// [sim/homseq_axis_model.sv]
// axis model: encoder steps, index, origin switch and overtravel limits
module homseq_axis_model (
    input wire logic mclk, // control clock
    input wire logic motorRun, // drive moves the axis
    input wire logic dirReverse, // 1 moves toward negative counts
    input wire logic parkEn, // relocate the axis this cycle
    input wire logic [31:0] parkPos, // relocation target, counts
    output logic [5:0] axisPins, // origin, index, step, dir, fwd, rev
    output logic tailDir, // direction of the latest run of steps
    output logic [31:0] tailCnt // steps in that run
);
    timeunit 1ns;
    timeprecision 1ns;
    logic signed [31:0] pos = 32'sh0;
    logic [2:0] phase = 3'h0;
    logic stepDir = 1'b0;
    initial tailDir = 1'b0;
    initial tailCnt = 32'h0;

    // one step per eight clocks, so a run ending on a step sees no stray one
    always @(posedge mclk) begin
        if (parkEn) begin
            pos <= parkPos;
            tailCnt <= 32'h0;
        end else if (motorRun) begin
            phase <= phase + 3'h1;
            if (phase == 3'h3) begin
                pos <= dirReverse ? pos - 1 : pos + 1;
                stepDir <= dirReverse;
                tailDir <= dirReverse;
                tailCnt <= (tailCnt != 0 && tailDir == dirReverse) ? tailCnt + 1 : 32'h1;
            end
        end
    end

    // switch levels follow position; the origin switch is valid when high
    assign axisPins = {pos >= 20 && pos <= 29, pos[3:0] == 4'h0, phase[2], stepDir,
                       pos >= 60, pos <= -60};
endmodule : homseq_axis_model

// [sim/tb_homing_sequencer.sv]
// self-checking bench for the homing sequencer
module tb_homing_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic servoOn = 1'b0;
    logic powerUpLoad = 1'b0;
    logic homeStart = 1'b0;
    logic posCompleted = 1'b0;
    logic parkEn = 1'b0;
    logic [31:0] parkPos = 32'h0;
    logic hreadyout, hresp, dirReverse, motorRun, homeDone, homingBusy, tailDir;
    logic [31:0] hrdata, tailCnt, rd;
    logic [11:0] speedCmd;
    logic [5:0] axisPins;
    homseq_pkg::homseq_pins_t pins;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int runCnt = 0;

    assign pins = {axisPins, homeStart, posCompleted};
    always #25 mclk = ~mclk;

    homing_sequencer u_homing_sequencer (
        .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .pins, .servoOn, .powerUpLoad, .speedCmd,
        .dirReverse, .motorRun, .homeDone, .homingBusy
    );
    homseq_axis_model u_homseq_axis_model (
        .mclk, .motorRun, .dirReverse, .parkEn, .parkPos, .axisPins, .tailDir, .tailCnt
    );

    task automatic finish_test();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // watchdog well above the longest expected run of all scenarios
    always @(posedge mclk) begin
        cycles++;
        if (motorRun === 1'b1) runCnt++;
        if (cycles == 60000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpWord

    // single ahb transfer; hready is sampled, never assumed
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        cmpWord(rd, exp);
    endtask : rdChk

    task automatic kick();
        homeStart <= 1'b1;
        tick(4);
        homeStart <= 1'b0;
        tick(1);
    endtask : kick

    task automatic park(input logic [31:0] p);
        parkEn <= 1'b1;
        parkPos <= p;
        tick(1);
        parkEn <= 1'b0;
        tick(4);
    endtask : park

    // a method only takes hold at the power-up pulse
    task automatic load(input logic [31:0] m);
        ahb(1'b1, 32'h14, m);
        powerUpLoad <= 1'b1;
        tick(1);
        powerUpLoad <= 1'b0;
    endtask : load

    task automatic regs();
        rdChk(32'h04, 32'h5DC);
        rdChk(32'h08, 32'h1E);
        rdChk(32'h18, 32'h64);
        rdChk(32'h0C, 32'h0);
        rdChk(32'h40, 32'h0);
        ahb(1'b1, 32'h04, 32'hFA0);
        rdChk(32'h04, 32'hBB8);
        ahb(1'b1, 32'h08, 32'hFA);
        rdChk(32'h08, 32'hC8);
        ahb(1'b1, 32'h0C, 32'hFFFF_D8EF);
        rdChk(32'h0C, 32'hFFFF_D8F1);
        ahb(1'b1, 32'h18, 32'h0);
        ahb(1'b1, 32'h00, 32'h13);
    endtask : regs

    // pending method 1 must not replace active method 0 yet
    task automatic pendingMethod();
        int r0;
        ahb(1'b1, 32'h14, 32'h1);
        rdChk(32'h14, 32'h1);
        r0 = runCnt;
        kick();
        tick(4);
        cmpWord({31'h0, homeDone}, 32'h1);
        cmpWord(runCnt, r0);
    endtask : pendingMethod

    task automatic refuse(input logic posc, input logic [31:0] p);
        int r0;
        r0 = runCnt;
        posCompleted <= posc;
        park(p);
        kick();
        tick(6);
        cmpWord(runCnt, r0);
        cmpWord({31'h0, homeDone}, 32'h1);
        posCompleted <= 1'b1;
        tick(1);
    endtask : refuse

    // full run; the last run of encoder steps shows whether the offset moved
    task automatic run(input int m, input int crs, input int fin, input int chk);
        int ofs;
        int i;
        bit keep;
        ofs = crs * 10000 + fin;
        keep = !((m == 7 || m == 9) && ofs > 0) && !((m == 8 || m == 10) && ofs < 0);
        ahb(1'b1, 32'h0C, crs);
        ahb(1'b1, 32'h10, fin);
        park((m % 2 == 1) ? 0 : 40);
        load(m);
        if (m != 11) kick();
        for (i = 0; i < 40 && motorRun !== 1'b1; i++) tick(1);
        if (chk == 1) begin
            tick(6);
            cmpWord({20'h0, speedCmd}, 32'hBB8);
            for (i = 0; i < 2000 && dirReverse !== 1'b1; i++) tick(1);
            tick(6);
            cmpWord({20'h0, speedCmd}, 32'hC8);
        end
        if (chk == 2) begin
            tick(100);
            cmpWord({31'h0, speedCmd > 12'h002 && speedCmd < 12'h009}, 32'h1);
        end
        for (i = 0; i < 3000 && homeDone !== 1'b1; i++) tick(1);
        cmpWord({31'h0, homeDone}, 32'h1);
        cmpWord({31'h0, tailDir}, 32'(keep ? ofs < 0 : m % 2 == 1));
        if (keep && (ofs < 0) != (m % 2 == 1))
            cmpWord(tailCnt, 32'(ofs < 0 ? -ofs : ofs));
        rdChk(32'h20, 32'h0);
    endtask : run

    initial begin
        int m;
        tick(20);
        rst <= 1'b0;
        servoOn <= 1'b1;
        posCompleted <= 1'b1;
        tick(2);
        regs();
        pendingMethod();
        load(32'h1);
        refuse(1'b0, 32'h0);
        refuse(1'b1, 32'd60);
        refuse(1'b1, -32'sd60);
        load(32'hC);
        refuse(1'b1, 32'h0);
        run(1, 0, 3, 1);
        for (m = 1; m <= 11; m++) run(m, 0, 3, 0);
        for (m = 7; m <= 10; m++) run(m, 0, -3, 0);
        run(1, 1, -9998, 0);
        ahb(1'b1, 32'h18, 32'h1);
        run(1, 0, 3, 2);
        finish_test();
    end
endmodule : tb_homing_sequencer
